// ---- core/aof_pkg.sv ----
package aof_pkg;

  // ---------------------------------------------------------------
  // sample and bus widths
  // ---------------------------------------------------------------
  localparam int unsigned SAMPLE_W  = 12;
  localparam int unsigned IDX_W     = 10;
  localparam int unsigned USER_N    = 4;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_TEST_CTRL  = 10'h00D;
  localparam logic [IDX_W-1:0] IDX_OFFSET     = 10'h010;
  localparam logic [IDX_W-1:0] IDX_OUT_MODE   = 10'h014;
  localparam logic [IDX_W-1:0] IDX_USER_FIRST = 10'h019;
  localparam logic [IDX_W-1:0] IDX_USER_LAST  = 10'h020;
  localparam logic [IDX_W-1:0] IDX_TRANSFER   = 10'h0FF;
  localparam logic [IDX_W-1:0] IDX_STATUS     = 10'h100;

  // ---------------------------------------------------------------
  // field positions and writable masks
  // ---------------------------------------------------------------
  localparam int unsigned TC_MODE_LSB     = 0;
  localparam int unsigned TC_PRBS_RST_BIT = 5;
  localparam int unsigned TC_SINGLE_BIT   = 7;
  localparam int unsigned OM_CODING_LSB   = 0;
  localparam int unsigned OM_INVERT_BIT   = 2;
  localparam int unsigned OM_DISABLE_BIT  = 4;
  localparam int unsigned XFER_BIT        = 0;
  localparam logic [7:0]  TC_MASK         = 8'hBF;
  localparam logic [7:0]  OM_MASK         = 8'h17;
  localparam logic [7:0]  OFS_MASK        = 8'h3F;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] TEST_CTRL_RST = 8'h00;
  localparam logic [7:0] OUT_MODE_RST  = 8'h01;
  localparam logic [7:0] OFFSET_RST    = 8'h00;
  localparam logic [7:0] USER_RST      = 8'h00;

  // ---------------------------------------------------------------
  // test generation codes and output coding
  // ---------------------------------------------------------------
  localparam logic [3:0] TM_OFF     = 4'h0;
  localparam logic [3:0] TM_MID     = 4'h1;
  localparam logic [3:0] TM_POS_FS  = 4'h2;
  localparam logic [3:0] TM_NEG_FS  = 4'h3;
  localparam logic [3:0] TM_CHECKER = 4'h4;
  localparam logic [3:0] TM_PRBS    = 4'h5;
  localparam logic [3:0] TM_TOGGLE  = 4'h7;
  localparam logic [3:0] TM_USER    = 4'h8;
  localparam logic [3:0] TM_RAMP    = 4'hF;
  localparam logic [1:0] CODE_OFFSET_BIN = 2'h0;
  localparam logic [1:0] CODE_TWOS       = 2'h1;

  // ---------------------------------------------------------------
  // pattern words (twos complement view)
  // ---------------------------------------------------------------
  localparam logic [SAMPLE_W-1:0] PAT_MID     = 12'h000;
  localparam logic [SAMPLE_W-1:0] PAT_POS_FS  = 12'h7FF;
  localparam logic [SAMPLE_W-1:0] PAT_NEG_FS  = 12'h800;
  localparam logic [SAMPLE_W-1:0] PAT_CHECK_A = 12'hAAA;
  localparam logic [SAMPLE_W-1:0] PAT_ONES    = 12'hFFF;
  localparam logic [SAMPLE_W-1:0] PAT_ZERO    = 12'h000;

  // ---------------------------------------------------------------
  // long pseudo-random sequence: x^23 + x^18 + 1
  // ---------------------------------------------------------------
  localparam int unsigned PRBS_W    = 23;
  localparam int unsigned PRBS_TAP  = 18;
  localparam logic [22:0] PRBS_SEED = 23'h7FFFFF;

  // ---------------------------------------------------------------
  // bus, carriers and states
  // ---------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic                valid;
    logic [SAMPLE_W-1:0] data;
  } aof_sample_t;

  typedef struct packed {
    logic [7:0] test_ctrl;
    logic [7:0] out_mode;
    logic [7:0] offset;
  } aof_cfg_t;

  typedef enum logic [2:0] {
    US_W1   = 3'h0,
    US_W2   = 3'h1,
    US_W3   = 3'h3,
    US_W4   = 3'h2,
    US_DONE = 3'h6
  } aof_useq_t;

endpackage : aof_pkg

// ---- core/aof_prbs_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module aof_prbs_gen
  import aof_pkg::*;
(
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // control
  input  wire logic                hold,
  // pattern word
  output var  logic [SAMPLE_W-1:0] word,
  output var  logic [PRBS_W-1:0]   state
);

  // ---------------------------------------------------------------
  // twelve lfsr steps per clock
  // ---------------------------------------------------------------
  logic [PRBS_W-1:0]   chain [0:SAMPLE_W];
  logic [SAMPLE_W-1:0] next_word;

  assign chain[0] = state;

  for (genvar i = 0; i < SAMPLE_W; i++) begin : g_step
    assign chain[i+1]         = {chain[i][PRBS_W-2:0],
                                 chain[i][PRBS_W-1] ^ chain[i][PRBS_TAP-1]};
    assign next_word[SAMPLE_W-1-i] = chain[i][PRBS_W-1];
  end

  // state held at seed while hold is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= PRBS_SEED;
      word  <= PAT_ZERO;
    end else if (hold) begin
      state <= PRBS_SEED;
      word  <= PAT_ZERO;
    end else begin
      state <= chain[SAMPLE_W];
      word  <= next_word;
    end
  end

endmodule : aof_prbs_gen
`default_nettype wire

// ---- core/aof_format.sv ----
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module aof_format
  import aof_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp,
  // converter core samples
  input  wire aof_sample_t core_sample,
  // formatted samples to the framer
  output var  aof_sample_t out_sample
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic [IDX_W:0] word_index(input logic [31:0] a);
    word_index = {(a[1:0] == 2'h0) && (a[31:IDX_W+2] == '0), a[IDX_W+1:2]};
  endfunction : word_index

  logic [IDX_W:0]   ap_dec;
  logic             ap_take;
  logic             dp_write;
  logic [IDX_W:0]   dp_dec;
  aof_cfg_t         shadow;
  aof_cfg_t         active;
  logic [7:0]       user_sh  [2*USER_N];
  logic [7:0]       user_act [2*USER_N];
  logic             xfer_pending;
  logic [IDX_W-1:0] rd_idx;
  logic [31:0]      rd_data;
  logic             wr_en;
  logic [IDX_W-1:0] wr_idx;
  logic             wr_user;
  logic [IDX_W-1:0] wr_user_off;
  logic             rd_user;
  logic [IDX_W-1:0] rd_user_off;

  // address phase and data phase qualifiers
  assign ap_dec      = word_index(haddr);
  assign ap_take     = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign rd_idx      = ap_dec[IDX_W-1:0];
  assign wr_en       = dp_write && dp_dec[IDX_W];
  assign wr_idx      = dp_dec[IDX_W-1:0];
  assign wr_user     = wr_en && (wr_idx >= IDX_USER_FIRST) && (wr_idx <= IDX_USER_LAST);
  assign wr_user_off = wr_idx - IDX_USER_FIRST;
  assign rd_user     = ap_dec[IDX_W] && (rd_idx >= IDX_USER_FIRST) && (rd_idx <= IDX_USER_LAST);
  assign rd_user_off = rd_idx - IDX_USER_FIRST;

  // ---------------------------------------------------------------
  // read mux (shadow values, own status)
  // ---------------------------------------------------------------
  logic [3:0]   act_mode;
  aof_useq_t    useq;
  logic [7:0]   status_byte;

  assign status_byte = {useq == US_DONE, xfer_pending, 2'h0, act_mode};

  always_comb begin
    rd_data = 32'h0000_0000;
    if (!ap_dec[IDX_W]) begin
      rd_data = 32'h0000_0000;
    end else if (rd_user) begin
      rd_data[7:0] = user_sh[rd_user_off[2:0]];
    end else begin
      unique case (rd_idx)
        IDX_TEST_CTRL: rd_data[7:0] = shadow.test_ctrl;
        IDX_OFFSET:    rd_data[7:0] = shadow.offset;
        IDX_OUT_MODE:  rd_data[7:0] = shadow.out_mode;
        IDX_TRANSFER:  rd_data[7:0] = {7'h00, xfer_pending};
        IDX_STATUS:    rd_data[7:0] = status_byte;
        default:       rd_data = 32'h0000_0000;
      endcase
    end
  end

  // bus slave: zero wait states, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write  <= 1'b0;
      dp_dec    <= '0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      dp_write  <= ap_take && hwrite;
      dp_dec    <= ap_dec;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ap_take && !hwrite) begin
        hrdata <= rd_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // shadow registers and transfer
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shadow.test_ctrl <= TEST_CTRL_RST;
      shadow.out_mode  <= OUT_MODE_RST;
      shadow.offset    <= OFFSET_RST;
      xfer_pending     <= 1'b0;
    end else begin
      if (wr_en && wr_idx == IDX_TEST_CTRL) begin
        shadow.test_ctrl <= hwdata[7:0] & TC_MASK;
      end
      if (wr_en && wr_idx == IDX_OUT_MODE) begin
        shadow.out_mode <= hwdata[7:0] & OM_MASK;
      end
      if (wr_en && wr_idx == IDX_OFFSET) begin
        shadow.offset <= hwdata[7:0] & OFS_MASK;
      end
      // transfer bit clears itself one cycle after it is set
      xfer_pending <= wr_en && (wr_idx == IDX_TRANSFER) && hwdata[XFER_BIT];
    end
  end

  for (genvar i = 0; i < 2 * USER_N; i++) begin : g_user
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        user_sh[i]  <= USER_RST;
        user_act[i] <= USER_RST;
      end else begin
        if (wr_user && wr_user_off[2:0] == 3'(i)) begin
          user_sh[i] <= hwdata[7:0];
        end
        if (xfer_pending) begin
          user_act[i] <= user_sh[i];
        end
      end
    end
  end

  // all shadowed values go live together
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active.test_ctrl <= TEST_CTRL_RST;
      active.out_mode  <= OUT_MODE_RST;
      active.offset    <= OFFSET_RST;
    end else if (xfer_pending) begin
      active <= shadow;
    end
  end

  // ---------------------------------------------------------------
  // active configuration fields
  // ---------------------------------------------------------------
  logic       act_single;
  logic       act_prbs_hold;
  logic       act_disable;
  logic       act_invert;
  logic [1:0] act_coding;

  assign act_mode      = active.test_ctrl[TC_MODE_LSB+:4];
  assign act_single    = active.test_ctrl[TC_SINGLE_BIT];
  assign act_prbs_hold = active.test_ctrl[TC_PRBS_RST_BIT];
  assign act_disable   = active.out_mode[OM_DISABLE_BIT];
  assign act_invert    = active.out_mode[OM_INVERT_BIT];
  assign act_coding    = active.out_mode[OM_CODING_LSB+:2];

  // ---------------------------------------------------------------
  // pattern sources
  // ---------------------------------------------------------------
  logic [SAMPLE_W-1:0] prbs_word;
  logic [PRBS_W-1:0]   prbs_state;
  logic                phase;
  logic [SAMPLE_W-1:0] ramp;
  aof_useq_t           next_useq;
  logic [1:0]          user_sel;
  logic [15:0]         user_word;

  aof_prbs_gen u_prbs (
    .hclk    (hclk),
    .hresetn (hresetn),
    .hold    (act_prbs_hold),
    .word    (prbs_word),
    .state   (prbs_state)
  );

  // user sequence: words one to four, repeat or once
  always_comb begin
    next_useq = useq;
    unique case (useq)
      US_W1:   next_useq = US_W2;
      US_W2:   next_useq = US_W3;
      US_W3:   next_useq = US_W4;
      US_W4:   next_useq = act_single ? US_DONE : US_W1;
      US_DONE: next_useq = US_DONE;
      default: next_useq = US_W1;
    endcase
  end

  assign user_sel  = {useq == US_W3 || useq == US_W4, useq == US_W2 || useq == US_W4};
  assign user_word = {user_act[{user_sel, 1'b1}], user_act[{user_sel, 1'b0}]};

  // phase toggles every clock; ramp and sequence advance only in their own test mode, else reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= 1'b0;
      ramp  <= PAT_ZERO;
      useq  <= US_W1;
    end else begin
      phase <= ~phase;
      ramp  <= (act_mode == TM_RAMP) ? ramp + 12'h001 : PAT_ZERO;
      useq  <= (act_mode == TM_USER && !xfer_pending) ? next_useq : US_W1;
    end
  end

  // ---------------------------------------------------------------
  // sample path: offset, saturate, invert, coding
  // ---------------------------------------------------------------
  logic signed [SAMPLE_W:0] ofs_sum;
  logic [SAMPLE_W-1:0]      ofs_sat;
  logic [SAMPLE_W-1:0]      conv_word;
  logic [SAMPLE_W-1:0]      test_word;
  logic                     test_raw;
  logic [SAMPLE_W-1:0]      sel_word;
  logic [SAMPLE_W-1:0]      coded_word;

  assign ofs_sum   = $signed({core_sample.data[SAMPLE_W-1], core_sample.data})
                   + $signed({{7{active.offset[5]}}, active.offset[5:0]});
  assign ofs_sat   = (ofs_sum > $signed({1'b0, PAT_POS_FS})) ? PAT_POS_FS :
                     (ofs_sum < $signed({1'b1, PAT_NEG_FS})) ? PAT_NEG_FS :
                     ofs_sum[SAMPLE_W-1:0];
  assign conv_word = act_invert ? ~ofs_sat : ofs_sat;

  // test word select; raw patterns skip the coding stage
  always_comb begin
    test_word = PAT_ZERO;
    test_raw  = 1'b1;
    unique case (act_mode)
      TM_MID:     begin test_word = PAT_MID;    test_raw = 1'b0; end
      TM_POS_FS:  begin test_word = PAT_POS_FS; test_raw = 1'b0; end
      TM_NEG_FS:  begin test_word = PAT_NEG_FS; test_raw = 1'b0; end
      TM_CHECKER: test_word = phase ? ~PAT_CHECK_A : PAT_CHECK_A;
      TM_PRBS:    test_word = prbs_word;
      TM_TOGGLE:  test_word = phase ? PAT_ONES : PAT_ZERO;
      TM_RAMP:    test_word = ramp;
      TM_USER:    test_word = (useq == US_DONE) ? PAT_ZERO : user_word[15:4];
      default:    test_word = PAT_ZERO;
    endcase
  end

  assign sel_word   = (act_mode == TM_OFF) ? conv_word : test_word;
  assign coded_word = (act_coding == CODE_OFFSET_BIN)
                    ? {~sel_word[SAMPLE_W-1], sel_word[SAMPLE_W-2:0]} : sel_word;

  // output register; disable blanks valid and data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_sample <= '0;
    end else if (act_disable) begin
      out_sample <= '0;
    end else begin
      out_sample.valid <= core_sample.valid;
      out_sample.data  <= (act_mode != TM_OFF || test_raw == 1'b0) && test_raw
                          ? test_word : coded_word;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_mid_twos;
    @(posedge hclk) disable iff (!hresetn)
    act_mode == TM_MID && !act_disable && act_coding == CODE_TWOS |=> out_sample.data == 12'h000;
  endproperty
  a_mid_twos: assert property (p_mid_twos) else $error("midscale not zero");
  property p_mid_ofsbin;
    @(posedge hclk) disable iff (!hresetn)
    act_mode == TM_MID && !act_disable && act_coding == CODE_OFFSET_BIN
      |=> out_sample.data == 12'h800;
  endproperty
  a_mid_ofsbin: assert property (p_mid_ofsbin) else $error("offset binary midscale");
  property p_toggle;
    @(posedge hclk) disable iff (!hresetn)
    (act_mode == TM_TOGGLE && !act_disable)[*3] |-> out_sample.data == ~$past(out_sample.data);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle word did not flip");
  property p_user_repeat;
    @(posedge hclk) disable iff (!hresetn)
    act_mode == TM_USER && !act_single && !xfer_pending && useq == US_W4 |=> useq == US_W1;
  endproperty
  a_user_repeat: assert property (p_user_repeat) else $error("user words did not repeat");
  sequence s_user_done;
    act_mode == TM_USER && useq == US_DONE && !act_disable && !xfer_pending;
  endsequence
  property p_user_single;
    @(posedge hclk) disable iff (!hresetn)
    s_user_done |=> out_sample.data == 12'h000;
  endproperty
  a_user_single: assert property (p_user_single) else $error("single mode not zero");
  property p_prbs_hold;
    @(posedge hclk) disable iff (!hresetn)
    act_prbs_hold |=> prbs_state == PRBS_SEED;
  endproperty
  a_prbs_hold: assert property (p_prbs_hold) else $error("generator not held");
  property p_disable;
    @(posedge hclk) disable iff (!hresetn)
    act_disable |=> !out_sample.valid && out_sample.data == 12'h000;
  endproperty
  a_disable: assert property (p_disable) else $error("outputs not disabled");
  property p_shadow_hold;
    @(posedge hclk) disable iff (!hresetn)
    !xfer_pending |=> active == $past(active);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("active changed early");
  property p_shadow_load;
    @(posedge hclk) disable iff (!hresetn)
    xfer_pending |=> active == $past(shadow) && !xfer_pending;
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("transfer not applied");
  property p_saturate;
    @(posedge hclk) disable iff (!hresetn)
    act_mode == TM_OFF && !act_disable && !act_invert && act_coding == CODE_TWOS
      && core_sample.data == 12'h7FF && !active.offset[5] |=> out_sample.data == 12'h7FF;
  endproperty
  a_saturate: assert property (p_saturate) else $error("offset did not saturate");

endmodule : aof_format
`default_nettype wire

// ---- tb/aof_framer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module aof_framer_model
  import aof_pkg::*;
(
  // clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // formatted samples in
  input  wire aof_sample_t         rx,
  // last word taken and word count
  output var  logic [SAMPLE_W-1:0] word,
  output var  int unsigned         n_words
);
  // takes only words marked valid, as a framer would
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      word    <= '0;
      n_words <= 0;
    end else if (rx.valid) begin
      word    <= rx.data;
      n_words <= n_words + 1;
    end
  end
endmodule : aof_framer_model
`default_nettype wire

// ---- tb/adc_output_test_and_format_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module adc_output_test_and_format_tb_top;
  import aof_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hrdy;
  logic        hresp_s;
  aof_sample_t core_sample;
  aof_sample_t out_s;
  logic [11:0] fr_word;
  int unsigned fr_cnt;
  int          n_mismatch;
  int          tests_run;
  logic [31:0] q;
  logic [11:0] a;
  logic [11:0] b;
  int unsigned c;
  // design and framer model
  aof_format dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy),
    .hresp(hresp_s), .core_sample(core_sample), .out_sample(out_s));
  aof_framer_model fr (.hclk(hclk), .hresetn(hresetn), .rx(out_s), .word(fr_word),
    .n_words(fr_cnt));
  // 10 MHz clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // waits for hready sampled high, bounded
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge hclk);
      if (hrdy === 1'b1) break;
    end
    if (n == 50) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask : wait_rdy
  // one single-word transfer: address phase, then data phase
  task automatic bus(input logic [IDX_W-1:0] idx, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {20'h00000, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, {24'h000000, d});
  endtask : wr
  task automatic rd(input logic [IDX_W-1:0] idx);
    bus(idx, 1'b0, 32'h0000_0000);
  endtask : rd
  // write one register, then commit all shadows
  task automatic cfg(input logic [IDX_W-1:0] idx, input logic [7:0] d);
    wr(idx, d);
    wr(IDX_TRANSFER, 8'h01);
  endtask : cfg
  task automatic look(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : look
  task automatic two(input logic [7:0] tc);
    cfg(IDX_TEST_CTRL, tc);
    look(4);
    a = out_s.data;
    look(1);
    b = out_s.data;
  endtask : two
  // sequence restarts at word one on transfer: first word two edges later
  task automatic useq(input logic [0:5][11:0] e);
    int n;
    look(2);
    chk(out_s.data, e[0]);
    for (n = 1; n < 6; n++) begin
      look(1);
      chk(out_s.data, e[n]);
    end
  endtask : useq
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    core_sample = '{valid: 1'b1, data: 12'h123};
    n_mismatch = 0;
    tests_run = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(IDX_TEST_CTRL); chk(q, 32'h0000_0000);
    rd(IDX_OUT_MODE); chk(q, 32'h0000_0001);
    chk(hresp_s, 1'b0);
    rd(10'h3FF); chk(q, 32'h0000_0000);
    look(2); chk(out_s, {1'b1, 12'h123});
    wr(IDX_OFFSET, 8'h1F);
    look(4); chk(out_s.data, 12'h123);
    wr(IDX_TRANSFER, 8'h01);
    look(4); chk(out_s.data, 12'h142);
    rd(IDX_TRANSFER); chk(q, 32'h0000_0000);
    @(posedge hclk);
    core_sample <= '{valid: 1'b1, data: 12'h7FF};
    look(2); chk(out_s.data, 12'h7FF);
    cfg(IDX_OFFSET, 8'h20);
    core_sample <= '{valid: 1'b1, data: 12'h123};
    look(4); chk(out_s.data, 12'h103);
    cfg(IDX_OFFSET, 8'h00);
    cfg(IDX_OUT_MODE, 8'h00);
    look(4); chk(out_s.data, 12'h923);
    cfg(IDX_OUT_MODE, 8'h11);
    look(4);
    c = fr_cnt;
    look(3); chk(out_s, 13'h0000);
    chk(fr_cnt - c, 32'h0000_0000);
    cfg(IDX_OUT_MODE, 8'h01);
    core_sample <= '{valid: 1'b0, data: 12'h123};
    look(4); chk(out_s.valid, 1'b0);
    @(posedge hclk);
    core_sample <= '{valid: 1'b1, data: 12'h123};
    two(8'h01); chk(b, PAT_MID);
    two(8'h02); chk(b, PAT_POS_FS);
    two(8'h03); chk(b, PAT_NEG_FS);
    two(8'h06); chk(b, 12'h000);
    two(8'h82); chk(b, PAT_POS_FS);
    two(8'h04); chk(a ^ b, 12'hFFF);
    chk(a == 12'hAAA || a == 12'h555, 1'b1);
    two(8'h07); chk(a ^ b, 12'hFFF);
    chk(a == 12'hFFF || a == 12'h000, 1'b1);
    two(8'h0F); chk(b, a + 12'h001);
    two(8'h25); chk(a | b, 12'h000);
    two(8'h05); chk(a != b, 1'b1);
    wr(IDX_USER_FIRST, 8'h30);
    wr(IDX_USER_FIRST + 10'h001, 8'h12);
    wr(IDX_USER_FIRST + 10'h002, 8'h60);
    wr(IDX_USER_FIRST + 10'h003, 8'h45);
    wr(IDX_USER_FIRST + 10'h004, 8'h90);
    wr(IDX_USER_FIRST + 10'h005, 8'h78);
    wr(IDX_USER_FIRST + 10'h006, 8'hC0);
    wr(IDX_USER_LAST, 8'hAB);
    rd(IDX_USER_FIRST + 10'h001); chk(q, 32'h0000_0012);
    cfg(IDX_TEST_CTRL, 8'h08);
    useq('{12'h123, 12'h456, 12'h789, 12'hABC, 12'h123, 12'h456});
    cfg(IDX_TEST_CTRL, 8'h88);
    useq('{12'h123, 12'h456, 12'h789, 12'hABC, 12'h000, 12'h000});
    rd(IDX_TEST_CTRL); chk(q, 32'h0000_0088);
    rd(IDX_STATUS); chk(q, 32'h0000_0088);
    report_and_stop();
  end
endmodule : adc_output_test_and_format_tb_top
`default_nettype wire
